// ---- epf_regs.svh ----
`ifndef EPF_REGS_SVH
`define EPF_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define EPF_OFS_CONTROL   8'h00
`define EPF_OFS_STATUS    8'h04
`define EPF_OFS_WATERMARK 8'h08
`define EPF_OFS_PAUSE_TMR 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EPF_CTL_DEC_BIT    0
`define EPF_CTL_MANUAL_BIT 4
`define EPF_CTL_AUTO_BIT   7
`define EPF_CTL_SPEED_BIT  8
`define EPF_STA_ACTIVE_BIT 0
`define EPF_STA_BUSY_BIT   1
`define EPF_STA_COUNT_LSB  16
`define EPF_WM_EMPTY_LSB   0
`define EPF_WM_FULL_LSB    8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EPF_RST_FULL_WM   8'hFF
`define EPF_RST_EMPTY_WM  8'h00
`define EPF_RST_PAUSE_TMR 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EPF_REF_CLK_KHZ     100000
`define EPF_TX_CLK_10_KHZ   2500
`define EPF_TX_CLK_100_KHZ  25000
`define EPF_DIV_10          (`EPF_REF_CLK_KHZ / `EPF_TX_CLK_10_KHZ)
`define EPF_DIV_100         (`EPF_REF_CLK_KHZ / `EPF_TX_CLK_100_KHZ)
`define EPF_RESEND_MULT     128
`define EPF_RESEND_DIV      2
`define EPF_RESEND_SHIFT    6

`endif

// ---- epf_pkg.sv ----
package epf_pkg;

   typedef enum logic [1:0]
   {
      EPF_IDLE = 2'b01,
      EPF_SEND = 2'b10
   } epf_state_t;

   typedef logic [7:0]  epf_count_t;
   typedef logic [15:0] epf_ptv_t;

endpackage : epf_pkg

// ---- epf_tick_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "epf_regs.svh"

module epf_tick_gen #(
   parameter int DIV_10  = `EPF_DIV_10,
   parameter int DIV_100 = `EPF_DIV_100
)(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic speed_100,
   output logic      tx_tick
);

   generate
      if (DIV_10 < 1 || DIV_100 < 1 || DIV_10 > 255 || DIV_100 > 255)
      begin : g_bad_div
         $error("epf_tick_gen: divider out of range");
      end
   endgenerate

   // ----------------------------------------------------------------
   // transmit clock rate stand-in
   // ----------------------------------------------------------------
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic [7:0] limit;

   always_comb
   begin
      limit = speed_100 ? 8'(DIV_100 - 1) : 8'(DIV_10 - 1);
      if (div_reg >= limit)
      begin
         div_next = 8'h00;
      end
      else
      begin
         div_next = div_reg + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_reg <= 8'h00;
      end
      else
      begin
         div_reg <= div_next;
      end
   end

   assign tx_tick = (div_reg >= limit);

endmodule : epf_tick_gen
`default_nettype wire

// ---- epf_buf_counter.sv ----
`timescale 1ns/10ps
`default_nettype none

module epf_buf_counter #(
   parameter int WIDTH = 8
)(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             inc,
   input  wire logic             dec,
   output logic [WIDTH-1:0]      count
);

   generate
      if (WIDTH < 1 || WIDTH > 8)
      begin : g_bad_width
         $error("epf_buf_counter: width must be 1 to 8");
      end
   endgenerate

   // ----------------------------------------------------------------
   // count arbitration
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   always_comb
   begin
      count_next = count_reg;
      if (inc && dec)
      begin
         count_next = count_reg;
      end
      else if (inc)
      begin
         // saturate, a wrap would fake an empty pool
         if (count_reg != {WIDTH{1'b1}})
         begin
            count_next = count_reg + 1'b1;
         end
      end
      else if (dec)
      begin
         if (count_reg != '0)
         begin
            count_next = count_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

endmodule : epf_buf_counter
`default_nettype wire

// ---- epf_flow_ctrl.sv ----
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "epf_regs.svh"

module epf_flow_ctrl (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        rx_buffer_done,
   output logic             pause_valid,
   input  wire logic        pause_ready,
   output logic [15:0]      pause_time,
   output logic             flow_control_active
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [21:0] resend_interval(input logic [15:0] pause_timer_value);
      logic [21:0] ivl;
      ivl = {pause_timer_value, 6'b00_0000};
      // zero would fire on every tick, as one does; one tick is the tightest legal spacing
      if (ivl == 22'h00_0000)
      begin
         ivl = 22'h00_0001;
      end
      return ivl;
   endfunction : resend_interval

   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       lane);
      return lane ? new_v : old_v;
   endfunction : merge_byte

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        bus_req;
   logic        wr_stb;
   logic        sel_ctl;
   logic        sel_sta;
   logic        sel_wm;
   logic        sel_ptv;

   // control and configuration
   logic        auto_pause_enable_reg;
   logic        auto_pause_enable_next;
   logic        manual_pause_enable_reg;
   logic        manual_pause_enable_next;
   logic        speed_100_reg;
   logic        speed_100_next;
   logic [7:0]  full_wm_reg;
   logic [7:0]  full_wm_next;
   logic [7:0]  empty_wm_reg;
   logic [7:0]  empty_wm_next;
   logic [15:0] pause_timer_value_reg;
   logic [15:0] pause_timer_value_next;
   logic        buffer_count_decrement;

   epf_pkg::epf_count_t received_buffer_count;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_stb  = bus_req && wb_we_i;
   assign sel_ctl = (wb_adr_i == `EPF_OFS_CONTROL);
   assign sel_sta = (wb_adr_i == `EPF_OFS_STATUS);
   assign sel_wm  = (wb_adr_i == `EPF_OFS_WATERMARK);
   assign sel_ptv = (wb_adr_i == `EPF_OFS_PAUSE_TMR);

   // strobe only, never stored
   assign buffer_count_decrement = wr_stb && sel_ctl && wb_sel_i[0]
                                   && wb_dat_i[`EPF_CTL_DEC_BIT];

   always_comb
   begin
      auto_pause_enable_next   = auto_pause_enable_reg;
      manual_pause_enable_next = manual_pause_enable_reg;
      speed_100_next           = speed_100_reg;
      full_wm_next             = full_wm_reg;
      empty_wm_next            = empty_wm_reg;
      pause_timer_value_next   = pause_timer_value_reg;
      if (wr_stb && sel_ctl)
      begin
         if (wb_sel_i[0])
         begin
            auto_pause_enable_next   = wb_dat_i[`EPF_CTL_AUTO_BIT];
            manual_pause_enable_next = wb_dat_i[`EPF_CTL_MANUAL_BIT];
         end
         if (wb_sel_i[1])
         begin
            speed_100_next = wb_dat_i[`EPF_CTL_SPEED_BIT];
         end
      end
      if (wr_stb && sel_wm)
      begin
         empty_wm_next = merge_byte(empty_wm_reg, wb_dat_i[7:0], wb_sel_i[0]);
         full_wm_next  = merge_byte(full_wm_reg, wb_dat_i[15:8], wb_sel_i[1]);
      end
      if (wr_stb && sel_ptv)
      begin
         pause_timer_value_next[7:0]  = merge_byte(pause_timer_value_reg[7:0],
                                                   wb_dat_i[7:0], wb_sel_i[0]);
         pause_timer_value_next[15:8] = merge_byte(pause_timer_value_reg[15:8],
                                                   wb_dat_i[15:8], wb_sel_i[1]);
      end
   end

   // ----------------------------------------------------------------
   // flow control state
   // ----------------------------------------------------------------
   epf_pkg::epf_state_t state_reg;
   epf_pkg::epf_state_t state_next;
   logic        auto_on_reg;
   logic        auto_on_next;
   logic        active_reg;
   logic        active_next;
   logic        on_pend_reg;
   logic        on_pend_next;
   logic        off_pend_reg;
   logic        off_pend_next;
   logic [21:0] resend_cnt_reg;
   logic [21:0] resend_cnt_next;
   logic [15:0] pause_time_reg;
   logic [15:0] pause_time_next;
   logic        tx_tick;
   logic        rise;
   logic        fall;
   logic        resend_due;

   assign rise = active_next && !active_reg;
   assign fall = !active_next && active_reg;
   assign resend_due = active_reg && tx_tick
                       && (resend_cnt_reg + 22'h00_0001
                           >= resend_interval(pause_timer_value_reg));

   always_comb
   begin
      auto_on_next = auto_on_reg;
      if (!auto_pause_enable_reg)
      begin
         auto_on_next = 1'b0;
      end
      else if (received_buffer_count >= full_wm_reg)
      begin
         auto_on_next = 1'b1;
      end
      else if (received_buffer_count <= empty_wm_reg)
      begin
         auto_on_next = 1'b0;
      end
      active_next = manual_pause_enable_reg || auto_on_next;

      // resend timer counts transmit clocks while the link is held off
      resend_cnt_next = resend_cnt_reg;
      if (!active_reg || rise || resend_due)
      begin
         resend_cnt_next = 22'h00_0000;
      end
      else if (tx_tick)
      begin
         resend_cnt_next = resend_cnt_reg + 22'h00_0001;
      end

      state_next      = state_reg;
      on_pend_next    = on_pend_reg;
      off_pend_next   = off_pend_reg;
      pause_time_next = pause_time_reg;
      unique case (state_reg)
         epf_pkg::EPF_IDLE:
         begin
            if (on_pend_reg)
            begin
               state_next      = epf_pkg::EPF_SEND;
               on_pend_next    = 1'b0;
               pause_time_next = pause_timer_value_reg;
            end
            else if (off_pend_reg)
            begin
               state_next      = epf_pkg::EPF_SEND;
               off_pend_next   = 1'b0;
               pause_time_next = 16'h0000;
            end
         end
         epf_pkg::EPF_SEND:
         begin
            if (pause_ready)
            begin
               state_next = epf_pkg::EPF_IDLE;
            end
         end
      endcase

      // new events win over the consuming clears above
      if (rise || resend_due)
      begin
         on_pend_next  = 1'b1;
         off_pend_next = 1'b0;
      end
      if (fall)
      begin
         off_pend_next = 1'b1;
         on_pend_next  = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb
   begin
      ack_next   = bus_req;
      rdata_next = rdata_reg;
      if (bus_req && !wb_we_i)
      begin
         rdata_next = 32'h0000_0000;
         if (sel_ctl)
         begin
            // decrement strobe always reads back zero
            rdata_next[`EPF_CTL_AUTO_BIT]   = auto_pause_enable_reg;
            rdata_next[`EPF_CTL_MANUAL_BIT] = manual_pause_enable_reg;
            rdata_next[`EPF_CTL_SPEED_BIT]  = speed_100_reg;
         end
         else if (sel_sta)
         begin
            rdata_next[`EPF_STA_COUNT_LSB +: 8] = received_buffer_count;
            rdata_next[`EPF_STA_ACTIVE_BIT]     = active_reg;
            rdata_next[`EPF_STA_BUSY_BIT]       = (state_reg == epf_pkg::EPF_SEND)
                                                  || on_pend_reg || off_pend_reg;
         end
         else if (sel_wm)
         begin
            rdata_next[`EPF_WM_EMPTY_LSB +: 8] = empty_wm_reg;
            rdata_next[`EPF_WM_FULL_LSB +: 8]  = full_wm_reg;
         end
         else if (sel_ptv)
         begin
            rdata_next[15:0] = pause_timer_value_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_reg                 <= 1'b0;
         rdata_reg               <= 32'h0000_0000;
         auto_pause_enable_reg   <= 1'b0;
         manual_pause_enable_reg <= 1'b0;
         speed_100_reg           <= 1'b0;
         full_wm_reg             <= `EPF_RST_FULL_WM;
         empty_wm_reg            <= `EPF_RST_EMPTY_WM;
         pause_timer_value_reg   <= `EPF_RST_PAUSE_TMR;
      end
      else
      begin
         ack_reg                 <= ack_next;
         rdata_reg               <= rdata_next;
         auto_pause_enable_reg   <= auto_pause_enable_next;
         manual_pause_enable_reg <= manual_pause_enable_next;
         speed_100_reg           <= speed_100_next;
         full_wm_reg             <= full_wm_next;
         empty_wm_reg            <= empty_wm_next;
         pause_timer_value_reg   <= pause_timer_value_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg      <= epf_pkg::EPF_IDLE;
         auto_on_reg    <= 1'b0;
         active_reg     <= 1'b0;
         on_pend_reg    <= 1'b0;
         off_pend_reg   <= 1'b0;
         resend_cnt_reg <= 22'h00_0000;
         pause_time_reg <= 16'h0000;
      end
      else
      begin
         state_reg      <= state_next;
         auto_on_reg    <= auto_on_next;
         active_reg     <= active_next;
         on_pend_reg    <= on_pend_next;
         off_pend_reg   <= off_pend_next;
         resend_cnt_reg <= resend_cnt_next;
         pause_time_reg <= pause_time_next;
      end
   end

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   epf_tick_gen u_tick (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .speed_100 (speed_100_reg),
      .tx_tick   (tx_tick)
   );

   epf_buf_counter #(
      .WIDTH (8)
   ) u_count (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .inc     (rx_buffer_done),
      .dec     (buffer_count_decrement),
      .count   (received_buffer_count)
   );

   assign wb_ack_o            = ack_reg;
   assign wb_dat_o            = rdata_reg;
   assign pause_valid         = (state_reg == epf_pkg::EPF_SEND);
   assign pause_time          = pause_time_reg;
   assign flow_control_active = active_reg;

endmodule : epf_flow_ctrl
`default_nettype wire

// ---- epf_flow_ctrl_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "epf_regs.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module epf_flow_ctrl_chk (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rx_buffer_done,
   input wire logic        pause_valid,
   input wire logic        pause_ready,
   input wire logic [15:0] pause_time,
   input wire logic        flow_control_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic rd_ack;
   logic mapped;
   assign rd_ack = wb_ack_o && !wb_we_i;
   assign mapped = (wb_adr_i == `EPF_OFS_CONTROL) || (wb_adr_i == `EPF_OFS_STATUS)
                   || (wb_adr_i == `EPF_OFS_WATERMARK) || (wb_adr_i == `EPF_OFS_PAUSE_TMR);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   strobe_reads_zero_a: assert property (rd_ack && wb_adr_i == `EPF_OFS_CONTROL |-> wb_dat_o[0] == 1'b0)
      else $error("decrement strobe read back as one");
   unmapped_zero_a: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   status_active_a: assert property (rd_ack && wb_adr_i == `EPF_OFS_STATUS |-> wb_dat_o[0] == $past(flow_control_active))
      else $error("status active bit disagrees with port");
   pause_hold_a: assert property (pause_valid && !pause_ready |=> pause_valid && $stable(pause_time))
      else $error("pause request dropped or changed before taken");
   pause_taken_a: assert property (pause_valid && pause_ready |=> !pause_valid)
      else $error("pause request not withdrawn after take");
   on_frame_a: assert property ($rose(flow_control_active) && !pause_valid |=> pause_valid)
      else $error("no pause frame after flow control on");
   off_frame_a: assert property ($fell(flow_control_active) && !pause_valid |=> pause_valid && pause_time == 16'h0000)
      else $error("no zero pause frame after flow control off");
   cover property ($fell(flow_control_active));
   cover property (rd_ack && !mapped);
   cover property (pause_valid && pause_ready && pause_time != 16'h0000);
endmodule : epf_flow_ctrl_chk

bind epf_flow_ctrl epf_flow_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_buffer_done(rx_buffer_done), .pause_valid(pause_valid),
   .pause_ready(pause_ready), .pause_time(pause_time), .flow_control_active(flow_control_active));
`default_nettype wire

// ---- epf_link_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// transmit side taking pause frames
// ----------------------------------------
module epf_link_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        pause_valid,
   input  wire logic [15:0] pause_time,
   output logic             pause_ready,
   output int               frames,
   output logic [15:0]      last_time,
   output int               last_at
);
   int now;
   int wait_cnt;
   // slow mode stalls ready, as a busy transmitter would
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         now <= 0;
         frames <= 0;
         last_time <= 16'h0000;
         last_at <= 0;
         wait_cnt <= 0;
         pause_ready <= 1'b0;
      end
      else
      begin
         now <= now + 1;
         if (pause_valid && pause_ready)
         begin
            frames <= frames + 1;
            last_time <= pause_time;
            last_at <= now;
         end
         wait_cnt <= (pause_valid && !pause_ready) ? wait_cnt + 1 : 0;
         pause_ready <= pause_valid && !pause_ready && (!slow || wait_cnt >= 3);
      end
   end
endmodule : epf_link_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "epf_regs.svh"
module tb_top;
   localparam int TICK10  = 40;
   localparam int TICK100 = 4;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic        rx_done = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        pv;
   logic        pr;
   logic [15:0] pt;
   logic        fca;
   logic [15:0] last_time;
   int          frames;
   int          last_at;
   int          err_count = 0;
   int          num_checks = 0;

   always #5 ref_clk = ~ref_clk;

   epf_flow_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .rx_buffer_done(rx_done), .pause_valid(pv), .pause_ready(pr), .pause_time(pt), .flow_control_active(fca));
   epf_link_model link (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .pause_valid(pv), .pause_time(pt),
      .pause_ready(pr), .frames(frames), .last_time(last_time), .last_at(last_at));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic inc,
                       output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      rx_done <= inc;
      @(posedge ref_clk);
      rx_done <= 1'b0;
      // no local limit: only the watchdog may end a stalled wait
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (ack !== 1'b1);
      chk("ack latency", 32'h0000_0001, 32'(n));
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, 1'b0, q);
   endtask : wr

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0000_0000, 1'b0, q);
      chk(name, exp, q);
   endtask : rd_chk

   task automatic pulses(input int n);
      repeat (n)
      begin
         rx_done <= 1'b1;
         @(posedge ref_clk);
         rx_done <= 1'b0;
         @(posedge ref_clk);
      end
   endtask : pulses

   task automatic wait_frame(input int cnt, input string name, input logic [15:0] exp);
      int n;
      n = 0;
      while (frames < cnt && n < 6000)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk({name, " count"}, 32'(cnt), 32'(frames));
      chk(name, 32'(exp), 32'(last_time));
   endtask : wait_frame

   // phase of the tick divider allows a few cycles of slack
   task automatic gap(input int exp, input string name, input logic [15:0] t);
      int t0;
      int d;
      t0 = last_at;
      wait_frame(frames + 1, name, t);
      d = last_at - t0;
      chk(name, 32'(exp), 32'((d >= exp - 8 && d <= exp + 8) ? exp : d));
   endtask : gap
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd_chk("control", `EPF_OFS_CONTROL, 32'h0000_0000);
      rd_chk("status", `EPF_OFS_STATUS, 32'h0000_0000);
      rd_chk("watermark", `EPF_OFS_WATERMARK, 32'h0000_ff00);
      rd_chk("ptv", `EPF_OFS_PAUSE_TMR, 32'h0000_0000);
      wr(8'h10, 32'hffff_ffff);
      rd_chk("unmapped", 8'h10, 32'h0000_0000);
      rd_chk("watermark", `EPF_OFS_WATERMARK, 32'h0000_ff00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_count;
      logic [31:0] q;
      pulses(3);
      rd_chk("count", `EPF_OFS_STATUS, 32'h0003_0000);
      wr(`EPF_OFS_CONTROL, 32'h0000_0001);
      rd_chk("count", `EPF_OFS_STATUS, 32'h0002_0000);
      rd_chk("strobe", `EPF_OFS_CONTROL, 32'h0000_0000);
      wr(`EPF_OFS_CONTROL, 32'h0000_0000);
      rd_chk("count", `EPF_OFS_STATUS, 32'h0002_0000);
      xfer(1'b1, `EPF_OFS_CONTROL, 32'h0000_0001, 1'b1, q);
      rd_chk("count", `EPF_OFS_STATUS, 32'h0002_0000);
      $display("test count done");
   endtask : t_count

   task automatic t_manual;
      int f;
      wr(`EPF_OFS_PAUSE_TMR, 32'h0000_0002);
      f = frames;
      wr(`EPF_OFS_CONTROL, 32'h0000_0110);
      wait_frame(f + 1, "manual time", 16'h0002);
      chk("active", 32'h0000_0001, 32'(fca));
      rd_chk("control on", `EPF_OFS_CONTROL, 32'h0000_0110);
      rd_chk("status on", `EPF_OFS_STATUS, 32'h0002_0001);
      gap(128 * 2 / 2 * TICK100, "gap fast", 16'h0002);
      slow <= 1'b1;
      wr(`EPF_OFS_PAUSE_TMR, 32'h0000_0001);
      wr(`EPF_OFS_CONTROL, 32'h0000_0010);
      wait_frame(frames + 1, "new time", 16'h0001);
      gap(128 * 1 / 2 * TICK10, "gap slow", 16'h0001);
      f = frames;
      wr(`EPF_OFS_CONTROL, 32'h0000_0000);
      wait_frame(f + 1, "release", 16'h0000);
      chk("active", 32'h0000_0000, 32'(fca));
      slow <= 1'b0;
      $display("test manual done");
   endtask : t_manual

   task automatic t_auto;
      int f;
      wr(`EPF_OFS_WATERMARK, 32'h0000_0401);
      wr(`EPF_OFS_PAUSE_TMR, 32'h0000_0100);
      wr(`EPF_OFS_CONTROL, 32'h0000_0180);
      pulses(1);
      chk("below full", 32'h0000_0000, 32'(fca));
      f = frames;
      pulses(1);
      wait_frame(f + 1, "auto on", 16'h0100);
      chk("at full", 32'h0000_0001, 32'(fca));
      wr(`EPF_OFS_CONTROL, 32'h0000_0181);
      wr(`EPF_OFS_CONTROL, 32'h0000_0181);
      chk("above empty", 32'h0000_0001, 32'(fca));
      f = frames;
      wr(`EPF_OFS_CONTROL, 32'h0000_0181);
      wait_frame(f + 1, "auto off", 16'h0000);
      chk("at empty", 32'h0000_0000, 32'(fca));
      $display("test auto done");
   endtask : t_auto

   task automatic t_sat;
      wr(`EPF_OFS_CONTROL, 32'h0000_0000);
      pulses(260);
      rd_chk("saturate", `EPF_OFS_STATUS, 32'h00ff_0000);
      wr(`EPF_OFS_CONTROL, 32'h0000_0001);
      rd_chk("from max", `EPF_OFS_STATUS, 32'h00fe_0000);
      $display("test saturate done");
   endtask : t_sat

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk);
      // all settings written only after a full reset
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_count();
      t_manual();
      t_auto();
      t_sat();
      final_report();
   end

   initial
   begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      $display("watchdog expired");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
